// *** design/bss_pkg.sv ***
// constants and types for the bulk OUT stream selection block
package bss_pkg;
  localparam int          SID_W      = 16;
  localparam int          NUMP_W     = 5;
  localparam int          STREAM_CNT = 16;
  localparam int          IDX_W      = 4;
  localparam logic [15:0] SID_NOSTRM = 16'h0000;
  localparam logic [15:0] SID_PRIME  = 16'hFFFF;
  localparam logic [4:0]  RTY_NUMP   = 5'h01;
  localparam logic [15:0] READY_RST  = 16'h0000;

  typedef enum logic [2:0] {
    BSS_IDLE,
    BSS_START,
    BSS_PRIME,
    BSS_DEFER,
    BSS_SSEND,
    BSS_MOVE
  } bss_state_t;
endpackage

// *** design/bss_stream_sel.sv ***
// device-side stream selection for a bulk OUT stream pipe
`timescale 1ns/10ps
`default_nettype none
module bss_stream_sel (
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  // decoded packets from the protocol layer, one cycle each
  input  wire logic                      rx_dp_i,
  input  wire logic                      rx_dph_def_i,
  input  wire logic [bss_pkg::SID_W-1:0] rx_sid_i,
  input  wire logic                      rx_pp_i,
  input  wire logic                      rx_zlen_i,
  input  wire logic                      rx_err_i,
  // device class side
  input  wire logic                      prop_req_i,
  input  wire logic [bss_pkg::SID_W-1:0] prop_sid_i,
  input  wire logic [bss_pkg::NUMP_W-1:0] prop_nump_i,
  input  wire logic                      act_set_i,
  input  wire logic                      act_clr_i,
  input  wire logic [bss_pkg::SID_W-1:0] act_sid_i,
  // move data sub-machine
  input  wire logic                      mv_done_i,
  input  wire logic                      mv_not_ready_i,
  // transaction packets to send, one cycle each; then the move entry strobe and stream status
  output logic                           tx_erdy_o,
  output logic                           tx_nrdy_o,
  output logic                           tx_ack_rty_o,
  output logic [bss_pkg::SID_W-1:0]      tx_sid_o,
  output logic [bss_pkg::NUMP_W-1:0]     tx_nump_o,
  output logic                           mv_enter_o,
  output logic [bss_pkg::SID_W-1:0]      cur_sid_o,
  output logic [bss_pkg::STREAM_CNT-1:0] ready_o,
  output logic [2:0]                     state_o,
  output logic                           proto_err_o
);
  import bss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // identifier decode

  // true when the identifier names a data stream with a bit in the ready set
  function automatic logic is_data_sid(input logic [SID_W-1:0] sid);
    is_data_sid = (sid != SID_NOSTRM) && (sid != SID_PRIME)
                  && (sid < SID_W'(STREAM_CNT));
  endfunction

  function automatic logic [IDX_W-1:0] sid_idx(input logic [SID_W-1:0] sid);
    sid_idx = sid[IDX_W-1:0];
  endfunction

  bss_state_t             state_reg;
  logic [SID_W-1:0]       prop_sid_reg;
  logic [STREAM_CNT-1:0]  ready_reg;
  logic                   first_idle_reg;
  logic                   dp_prime;
  logic                   dp_nostrm;
  logic                   can_propose;
  logic                   start_hit;
  logic                   start_other;
  logic                   idle_host;

  // packet classes; checked only in the cycle a decode pulse arrives
  assign dp_prime    = rx_dp_i && (rx_sid_i == SID_PRIME) && !rx_pp_i && rx_zlen_i;
  assign dp_nostrm   = rx_dp_i && (rx_sid_i == SID_NOSTRM) && !rx_pp_i && rx_zlen_i;
  // a proposal is only legal for a ready stream with room to offer
  assign can_propose = prop_req_i && is_data_sid(prop_sid_i)
                       && ready_reg[sid_idx(prop_sid_i)]
                       && (prop_nump_i != '0);
  assign idle_host   = rx_dp_i && (rx_sid_i != SID_PRIME);
  assign start_hit   = rx_dp_i && (rx_sid_i == prop_sid_reg);
  assign start_other = rx_dp_i && (rx_sid_i != prop_sid_reg)
                       && (rx_sid_i != SID_PRIME) && (rx_sid_i != SID_NOSTRM);

  ////////////////////////////////////////////////////////////////////////////
  // stream protocol state; each change lands on a decode or send edge, except BSS_DEFER leaving on the next edge and BSS_MOVE on mv_done_i

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= BSS_IDLE;
    end else begin
      case (state_reg)
        BSS_IDLE: begin
          // deferred header outranks data: it carries no payload
          if (rx_dph_def_i) begin
            state_reg <= BSS_DEFER;
          end else if (rx_dp_i && rx_sid_i == SID_PRIME) begin
            if (!rx_err_i && dp_prime) begin
              state_reg <= BSS_PRIME;
            end
          end else if (idle_host) begin
            state_reg <= BSS_MOVE;
          end else if (can_propose) begin
            state_reg <= BSS_START;
          end
        end
        BSS_START: begin
          if (rx_dph_def_i) begin
            state_reg <= BSS_IDLE;
          end else if (dp_prime) begin
            state_reg <= BSS_PRIME;
          end else if (rx_dp_i && rx_sid_i == SID_NOSTRM) begin
            if (!rx_err_i && dp_nostrm) begin
              state_reg <= BSS_SSEND;
            end
          end else if (start_hit || start_other) begin
            state_reg <= BSS_MOVE;
          end
        end
        BSS_PRIME: state_reg <= BSS_IDLE;
        BSS_DEFER: state_reg <= BSS_IDLE;
        BSS_SSEND: state_reg <= BSS_IDLE;
        // accept or reject is decided inside move data
        BSS_MOVE: begin
          if (mv_done_i) begin
            state_reg <= BSS_IDLE;
          end
        end
        default: state_reg <= BSS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first idle entry: host may not select until device has proposed

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      first_idle_reg <= 1'b1;
      proto_err_o    <= 1'b0;
    end else begin
      if (state_reg == BSS_IDLE && !rx_dph_def_i && !rx_dp_i && can_propose) begin
        first_idle_reg <= 1'b0;
      end
      // sticky flag; a host selection before ours is still served
      if (state_reg == BSS_IDLE && first_idle_reg && !rx_dph_def_i && idle_host) begin
        proto_err_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // proposed and current stream

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prop_sid_reg <= SID_NOSTRM;
      cur_sid_o    <= SID_NOSTRM;
    end else begin
      if (state_reg == BSS_IDLE && !rx_dph_def_i && !rx_dp_i && can_propose) begin
        prop_sid_reg <= prop_sid_i;
      end
      if (state_reg == BSS_IDLE && !rx_dph_def_i && idle_host) begin
        cur_sid_o <= rx_sid_i;
      end
      if (state_reg == BSS_START && !rx_dph_def_i && !dp_prime
          && (start_hit || start_other)) begin
        cur_sid_o <= rx_sid_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active and ready set; hardware set wins over any clear in one cycle

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ready_reg <= READY_RST;
    end else begin
      if (act_clr_i && is_data_sid(act_sid_i)) begin
        ready_reg[sid_idx(act_sid_i)] <= 1'b0;
      end
      if (mv_not_ready_i && is_data_sid(cur_sid_o)) begin
        ready_reg[sid_idx(cur_sid_o)] <= 1'b0;
      end
      if (state_reg == BSS_START && !rx_dph_def_i && !dp_prime && dp_nostrm
          && !rx_err_i && is_data_sid(prop_sid_reg)) begin
        ready_reg[sid_idx(prop_sid_reg)] <= 1'b0;
      end
      if (act_set_i && is_data_sid(act_sid_i)) begin
        ready_reg[sid_idx(act_sid_i)] <= 1'b1;
      end
      if (((state_reg == BSS_IDLE && !rx_dph_def_i && idle_host)
           || (state_reg == BSS_START && !rx_dph_def_i && start_other))
          && is_data_sid(rx_sid_i)) begin
        ready_reg[sid_idx(rx_sid_i)] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ready_o <= READY_RST;
    end else begin
      ready_o <= ready_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction packets out; all one-cycle strobes with registered fields

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_erdy_o    <= 1'b0;
      tx_nrdy_o    <= 1'b0;
      tx_ack_rty_o <= 1'b0;
      tx_sid_o     <= SID_NOSTRM;
      tx_nump_o    <= '0;
      mv_enter_o   <= 1'b0;
    end else begin
      tx_erdy_o    <= 1'b0;
      tx_nrdy_o    <= 1'b0;
      tx_ack_rty_o <= 1'b0;
      mv_enter_o   <= 1'b0;
      case (state_reg)
        BSS_IDLE: begin
          if (rx_dph_def_i) begin
            tx_sid_o <= tx_sid_o;
          end else if (rx_dp_i && rx_sid_i == SID_PRIME) begin
            if (rx_err_i || !dp_prime) begin
              tx_ack_rty_o <= 1'b1;
              tx_sid_o     <= SID_PRIME;
              tx_nump_o    <= RTY_NUMP;
            end
          end else if (idle_host) begin
            mv_enter_o <= 1'b1;
          end else if (can_propose) begin
            tx_erdy_o <= 1'b1;
            tx_sid_o  <= prop_sid_i;
            tx_nump_o <= prop_nump_i;
          end
        end
        BSS_START: begin
          if (rx_dph_def_i) begin
            tx_sid_o <= tx_sid_o;
          end else if (dp_prime) begin
            tx_sid_o <= tx_sid_o;
          end else if (rx_dp_i && rx_sid_i == SID_NOSTRM) begin
            if (rx_err_i || !dp_nostrm) begin
              tx_ack_rty_o <= 1'b1;
              tx_sid_o     <= SID_NOSTRM;
              tx_nump_o    <= RTY_NUMP;
            end
          end else if (start_hit || start_other) begin
            mv_enter_o <= 1'b1;
          end
        end
        BSS_PRIME: begin
          tx_nrdy_o <= 1'b1;
          tx_sid_o  <= SID_PRIME;
        end
        BSS_SSEND: begin
          tx_nrdy_o <= 1'b1;
          tx_sid_o  <= SID_NOSTRM;
        end
        default: tx_sid_o <= tx_sid_o;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_o <= 3'h0;
    end else begin
      state_o <= state_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_defer_to_idle: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == BSS_DEFER |=> state_reg == BSS_IDLE)
    else $error("deferred prime did not go straight to idle");

  a_erdy_ready_only: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    // ready_o lags the set by one edge, so it shows the set the proposal was judged on
    tx_erdy_o |-> is_data_sid(tx_sid_o) && ready_o[sid_idx(tx_sid_o)] && tx_nump_o != '0)
    else $error("ERDY for a stream not ready or with zero NumP");

  a_erdy_enters_start: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    tx_erdy_o |-> state_reg == BSS_START && prop_sid_reg == tx_sid_o)
    else $error("ERDY sent without entering start stream");

  a_prime_nrdy_idle: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == BSS_PRIME |=> tx_nrdy_o && tx_sid_o == SID_PRIME
                               && state_reg == BSS_IDLE)
    else $error("prime pipe did not answer NRDY prime and go idle");

  a_ssend_nrdy_idle: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == BSS_SSEND |=> tx_nrdy_o && tx_sid_o == SID_NOSTRM
                               && state_reg == BSS_IDLE)
    else $error("start stream end did not answer NRDY no-stream");

  a_idle_host_move: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == BSS_IDLE && !rx_dph_def_i && idle_host
    |=> state_reg == BSS_MOVE && mv_enter_o && cur_sid_o == $past(rx_sid_i))
    else $error("host data in idle did not enter move data");

  a_prime_err_stay: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == BSS_IDLE && !rx_dph_def_i && rx_dp_i && rx_sid_i == SID_PRIME
    && rx_err_i |=> state_reg == BSS_IDLE && tx_ack_rty_o && tx_nump_o != '0)
    else $error("errored prime did not hold idle with retry ACK");

  a_reject_notready: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == BSS_START && !rx_dph_def_i && dp_nostrm && !rx_err_i
    |=> state_reg == BSS_SSEND ##1 !ready_o[sid_idx(prop_sid_reg)])
    else $error("rejection did not clear the proposed stream");

  a_start_race_prime: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == BSS_START && !rx_dph_def_i && dp_prime |=> state_reg == BSS_PRIME)
    else $error("prime race in start stream not resolved");

  a_start_deferred: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == BSS_START && rx_dph_def_i |=> state_reg == BSS_IDLE)
    else $error("deferred header in start stream did not return to idle");

  a_idle_deferred: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == BSS_IDLE && rx_dph_def_i |=> state_reg == BSS_DEFER)
    else $error("deferred header in idle did not enter deferred prime");

  a_nostrm_err_stay: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == BSS_START && !rx_dph_def_i && rx_dp_i && rx_sid_i == SID_NOSTRM
    && rx_err_i |=> state_reg == BSS_START && tx_ack_rty_o && tx_sid_o == SID_NOSTRM)
    else $error("errored rejection did not hold start stream");
endmodule
`default_nettype wire

// *** bench/bss_host_model.sv ***
// host-side model that feeds decoded packets into the stream block
`timescale 1ns/10ps
`default_nettype none
module bss_host_model (
  input  wire logic        clk_i,
  output logic             dp_o,
  output logic             dph_o,
  output logic [15:0]      sid_o,
  output logic             pp_o,
  output logic             zlen_o,
  output logic             err_o
);
  logic [15:0] has_data = 16'h0000;

  initial begin
    {dp_o, dph_o, sid_o, pp_o, zlen_o, err_o} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one packet per call; fields are scrambled after release so stale
  // values can never be mistaken for a valid packet
  task automatic pkt(input logic d, input logic [15:0] s, input logic p, z, e);
    @(posedge clk_i);
    #1;
    {dp_o, dph_o, sid_o, pp_o, zlen_o, err_o} = {~d, d, s, p, z, e};
    @(posedge clk_i);
    #1;
    {dp_o, dph_o} = 2'b00;
    sid_o = ~sid_o;
    pp_o = ~pp_o;
    zlen_o = ~zlen_o;
    err_o = ~err_o;
  endtask

  // answer a device proposal after dly cycles: data if has_data marks s, else a no-stream rejection
  task automatic answer(input logic [15:0] s, input int dly);
    repeat (dly) @(posedge clk_i);
    if (has_data[s[3:0]]) begin
      pkt(1'b0, s, 1'b1, 1'b0, 1'b0);
    end else begin
      pkt(1'b0, bss_pkg::SID_NOSTRM, 1'b0, 1'b1, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// *** bench/bss_stream_sel_tb_top.sv ***
// self-checking testbench for the bulk OUT stream selection block
`timescale 1ns/10ps
`default_nettype none
module bss_stream_sel_tb_top;
  import bss_pkg::*;
  logic        clk, srst, dp, dph, pp, zlen, err, prop_req, act_set, act_clr;
  logic        mv_done, mv_nr, erdy, nrdy, ack, mv_enter, perr;
  logic [15:0] sid, prop_sid, act_sid, tx_sid, cur_sid, ready;
  logic [4:0]  prop_nump, tx_nump;
  logic [2:0]  state;
  int          n_fail = 0;
  int          n_compared = 0;

  bss_host_model host (.clk_i(clk), .dp_o(dp), .dph_o(dph), .sid_o(sid),
    .pp_o(pp), .zlen_o(zlen), .err_o(err));

  bss_stream_sel dut (.sys_clk_i(clk), .srst_i(srst), .rx_dp_i(dp),
    .rx_dph_def_i(dph), .rx_sid_i(sid), .rx_pp_i(pp), .rx_zlen_i(zlen),
    .rx_err_i(err), .prop_req_i(prop_req), .prop_sid_i(prop_sid),
    .prop_nump_i(prop_nump), .act_set_i(act_set), .act_clr_i(act_clr),
    .act_sid_i(act_sid), .mv_done_i(mv_done), .mv_not_ready_i(mv_nr),
    .tx_erdy_o(erdy), .tx_nrdy_o(nrdy), .tx_ack_rty_o(ack), .tx_sid_o(tx_sid),
    .tx_nump_o(tx_nump), .mv_enter_o(mv_enter), .cur_sid_o(cur_sid),
    .ready_o(ready), .state_o(state), .proto_err_o(perr));

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // shared helpers; inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // wide enough for the whole reset snapshot of 57 bits
  task automatic chk(input logic [63:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // kind is {erdy, nrdy, ack}; the id is only meaningful with a pulse
  task automatic tx(input logic [2:0] k, input logic [15:0] s);
    chk({erdy, nrdy, ack}, k);
    if (k != 3'b000) chk(tx_sid, s);
  endtask

  task automatic do_reset;
    srst = 1'b1;
    step(8);
    srst = 1'b0;
    chk({state, ready, tx_sid, cur_sid, tx_nump, perr}, '0);
  endtask

  task automatic mark(input logic [15:0] s);
    act_sid = s;
    act_set = 1'b1;
    step(1);
    act_set = 1'b0;
    step(1);
  endtask

  task automatic propose(input logic [15:0] s, input logic [4:0] n);
    prop_sid = s;
    prop_nump = n;
    prop_req = 1'b1;
    step(1);
    prop_req = 1'b0;
  endtask

  task automatic leave_move;
    mv_done = 1'b1;
    step(1);
    mv_done = 1'b0;
    step(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // host selects before any proposal, then move data drops the stream
  task automatic t_host_first;
    host.pkt(1'b0, 16'h0005, 1'b1, 1'b0, 1'b0);
    chk({mv_enter, cur_sid}, {1'b1, 16'h0005});
    step(1);
    chk({ready[5], state}, {1'b1, 3'(BSS_MOVE)});
    chk(perr, 1'b1);
    mv_nr = 1'b1;
    mv_done = 1'b1;
    step(1);
    {mv_nr, mv_done} = 2'b00;
    step(2);
    chk({ready[5], state}, {1'b0, 3'(BSS_IDLE)});
    do_reset();
  endtask

  // prime in idle: errored and pending variants retried, clean one primes
  task automatic t_prime_idle;
    host.pkt(1'b0, SID_PRIME, 1'b0, 1'b1, 1'b1);
    tx(3'b001, SID_PRIME);
    chk(tx_nump, RTY_NUMP);
    host.pkt(1'b0, SID_PRIME, 1'b1, 1'b1, 1'b0);
    tx(3'b001, SID_PRIME);
    host.pkt(1'b0, SID_PRIME, 1'b0, 1'b1, 1'b0);
    tx(3'b000, 16'h0000);
    step(1);
    chk(state, 3'(BSS_PRIME));
    tx(3'b010, SID_PRIME);
    step(1);
    chk(state, 3'(BSS_IDLE));
  endtask

  // refused proposals, then deferred header in idle
  task automatic t_refuse_defer;
    propose(16'h0009, 5'h04);
    tx(3'b000, 16'h0000);
    mark(16'h0009);
    propose(16'h0009, 5'h00);
    tx(3'b000, 16'h0000);
    host.pkt(1'b1, 16'h0000, 1'b0, 1'b1, 1'b0);
    tx(3'b000, 16'h0000);
    step(1);
    chk(state, 3'(BSS_DEFER));
    step(1);
    chk(state, 3'(BSS_IDLE));
    propose(16'h0009, 5'h1F);
    tx(3'b100, 16'h0009);
    chk(tx_nump, 5'h1F);
    host.has_data[9] = 1'b1;
    host.answer(16'h0009, 3);
    chk({mv_enter, cur_sid}, {1'b1, 16'h0009});
    leave_move();
  endtask

  // proposal rejected, first with a damaged rejection packet
  task automatic t_reject;
    mark(16'h0004);
    propose(16'h0004, 5'h02);
    tx(3'b100, 16'h0004);
    chk(tx_nump, 5'h02);
    step(1);
    chk(state, 3'(BSS_START));
    host.pkt(1'b0, SID_NOSTRM, 1'b0, 1'b1, 1'b1);
    tx(3'b001, SID_NOSTRM);
    host.answer(16'h0004, 0);
    tx(3'b000, 16'h0000);
    step(1);
    tx(3'b010, SID_NOSTRM);
    chk(ready[4], 1'b0);
    step(1);
    chk(state, 3'(BSS_IDLE));
  endtask

  // crossing races and a deferred header while a proposal is out
  task automatic t_races;
    mark(16'h0002);
    propose(16'h0002, 5'h01);
    host.pkt(1'b0, SID_PRIME, 1'b0, 1'b1, 1'b0);
    step(1);
    tx(3'b010, SID_PRIME);
    step(1);
    propose(16'h0002, 5'h01);
    host.pkt(1'b0, 16'h0006, 1'b0, 1'b0, 1'b0);
    chk({mv_enter, cur_sid}, {1'b1, 16'h0006});
    step(1);
    chk(ready[6], 1'b1);
    leave_move();
    propose(16'h0002, 5'h01);
    host.pkt(1'b1, 16'h0000, 1'b0, 1'b1, 1'b0);
    step(2);
    chk(state, 3'(BSS_IDLE));
    propose(16'h0002, 5'h01);
    tx(3'b100, 16'h0002);
    host.pkt(1'b0, 16'h0002, 1'b0, 1'b0, 1'b0);
    chk({mv_enter, cur_sid}, {1'b1, 16'h0002});
    leave_move();
    act_sid = 16'h0002;
    act_clr = 1'b1;
    step(1);
    act_clr = 1'b0;
    step(1);
    chk(ready[2], 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict in one place, reached by the sequence or the watchdog
  task automatic report_and_stop;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence; the watchdog allows far more than the tests need
  initial begin
    {srst, prop_req, act_set, act_clr, mv_done, mv_nr} = 6'b100000;
    {prop_sid, act_sid, prop_nump} = '0;
    do_reset();
    t_host_first();
    t_prime_idle();
    t_refuse_defer();
    t_reject();
    t_races();
    report_and_stop();
  end

  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
